/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import wkt_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] rv;
    logic [7:0] wd;
    logic [7:0] av;
    logic       er;
  } wkt_row_s;
  wkt_row_s    rows [12] = '{
    '{OFS_CFG, 8'h00, 8'hE0, 8'hE0, 1'b0}, '{OFS_MANT_HI, 8'h00, 8'h5A, 8'h5A, 1'b0},
    '{OFS_MANT_LO, 8'h01, 8'hA5, 8'hA5, 1'b0}, '{OFS_EXP, 8'h00, 8'h3F, 8'h3F, 1'b0},
    '{OFS_WIN, 8'h01, 8'h7E, 8'h7E, 1'b0}, '{OFS_STATUS, 8'h00, 8'h1F, 8'h00, 1'b0},
    '{OFS_MASK, 8'h00, 8'h1F, 8'h1F, 1'b0}, '{OFS_CTRL, 8'h00, 8'h01, 8'h01, 1'b0},
    '{OFS_CMD, 8'h00, 8'h00, 8'h00, 1'b0}, '{OFS_STATE, 8'h01, 8'h00, 8'h01, 1'b0},
    '{OFS_TRIM, 8'h40, 8'h00, 8'h40, 1'b0}, '{8'h2C, 8'h00, 8'hFF, 8'h00, 1'b1}};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic        rc = 1'b0, xtal = 1'b0, xo_ref = 1'b0, xo_ready = 1'b0;
  logic        batt_low, rx_sync_det, rx_pkt_done, tx_done;
  logic        irq_out_n, xo_en, rx_on, tx_start, batt_check, rc_run, e;
  logic [6:0]  rc_trim, chip_state;
  int          errors = 0;
  int          n_tests = 0;
  int          div = 0;
  int          n;
  bit          hit;
  bit          fast = 1'b0;

  wkt_wake_timer wkt_wake_timer_i (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RC_CLK_32K(rc), .XTAL_CLK_32K(xtal), .XO_REF(xo_ref),
    .XO_READY(xo_ready), .BATT_LOW(batt_low), .RX_SYNC_DET(rx_sync_det),
    .RX_PKT_DONE(rx_pkt_done), .TX_DONE(tx_done), .IRQ_OUT_N(irq_out_n),
    .XO_EN(xo_en), .RC_TRIM(rc_trim), .RX_ON(rx_on), .TX_START(tx_start),
    .BATT_CHECK(batt_check), .CHIP_STATE(chip_state));
  wkt_host_model wkt_host_model_i (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Clocks and far-side sources
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Slow sources shortened: one tick is 40 clocks, reference 10 clocks;
  // fast RC (4 clocks a tick) for the shutdown exit calibration and to reach the long recalibration interval
  always @(posedge clk) begin
    div <= div + 1;
    if (div % 20 == 19) xtal <= ~xtal;
    if (div % (fast ? 2 : 20) == (fast ? 1 : 19)) rc <= rc_run ? ~rc : 1'b0;
    if (div % 5 == 4) xo_ref <= ~xo_ref;
    xo_ready <= xo_en;
  end

  // ----------------------------------------
  // Checking and waiting
  // ----------------------------------------
  task automatic end_sim();
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic hang();
    errors++;
    end_sim();
  endtask : hang

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] v);
    wkt_host_model_i.xfer(1'b1, a, {24'h0, v}, d, e);
  endtask : w

  task automatic r(input logic [7:0] a);
    wkt_host_model_i.xfer(1'b0, a, 32'h0, d, e);
  endtask : r

  task automatic wait_sig(input int s, input int lim, input bit must);
    hit = 1'b0;
    n = 0;
    while (n < lim && !hit) begin
      @(posedge clk);
      n++;
      case (s)
        0: hit = (batt_check === 1'b1);
        1: hit = (tx_start === 1'b1);
        2: hit = (rx_on === 1'b1);
        3: hit = (rx_on === 1'b0);
        4: hit = (xo_en === 1'b1);
        default: hit = (chip_state === 7'h01);
      endcase
    end
    if (must && !hit) hang();
  endtask : wait_sig

  initial begin
    rst = 1'b1;
    {batt_low, rx_sync_det, rx_pkt_done, tx_done} = 4'h8;
    rc_run = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(irq_out_n, 1'b1);
    chk(rc_trim, 7'h40);
    chk(chip_state, 7'h01);
    foreach (rows[i]) begin
      r(rows[i].a);
      chk(d, {24'h0, rows[i].rv});
      chk(e, rows[i].er);
      w(rows[i].a, rows[i].wd);
      r(rows[i].a);
      chk(d, {24'h0, rows[i].av});
    end
    w(OFS_CMD, 8'h01);
    wait_sig(4, 100, 1'b1);
    chk(chip_state, 7'h08);
    wait_sig(5, 3000, 1'b1);
    chk(rc_trim, 7'h41);
    chk(xo_en, 1'b0);
    r(OFS_STATUS);
    chk(d, 32'h02);
    w(OFS_STATUS, 8'h02);
    w(OFS_CTRL, 8'h00);
    w(OFS_MANT_HI, 8'h00);
    w(OFS_MANT_LO, 8'h02);
    w(OFS_EXP, 8'h21);
    w(OFS_MASK, 8'h01);
    w(OFS_CFG, 8'h03);
    w(OFS_CMD, 8'h02);
    wait_sig(0, 2000, 1'b1);
    wait_sig(0, 2000, 1'b1);
    chk(n, 640);
    repeat (3) @(posedge clk);
    chk(irq_out_n, 1'b0);
    chk(chip_state, 7'h02);
    wkt_host_model_i.service(d);
    chk(d, 32'h05);
    repeat (3) @(posedge clk);
    chk(irq_out_n, 1'b1);
    w(OFS_MASK, 8'h00);
    wait_sig(0, 2000, 1'b1);
    repeat (3) @(posedge clk);
    chk(irq_out_n, 1'b1);
    wkt_host_model_i.service(d);
    chk(d, 32'h05);
    // Stop the RC source so only the crystal can advance the count
    w(OFS_CTRL, 8'h01);
    rc_run <= 1'b0;
    wait_sig(0, 2000, 1'b1);
    wait_sig(0, 2000, 1'b1);
    chk(n, 640);
    rc_run <= 1'b1;
    w(OFS_CTRL, 8'h00);
    w(OFS_CFG, 8'h00);
    wkt_host_model_i.service(d);
    wait_sig(0, 1400, 1'b0);
    chk(hit, 1'b0);
    r(OFS_STATUS);
    chk(d, 32'h00);
    w(OFS_CMD, 8'h10);
    w(OFS_EXP, 8'h01);
    w(OFS_CFG, 8'h03);
    w(OFS_CMD, 8'h02);
    wait_sig(0, 2000, 1'b1);
    repeat (2) @(posedge clk);
    chk(chip_state, 7'h01);
    w(OFS_CFG, 8'h00);
    wkt_host_model_i.service(d);
    w(OFS_MASK, 8'h10);
    w(OFS_CFG, 8'h09);
    w(OFS_CMD, 8'h02);
    wait_sig(1, 2000, 1'b1);
    repeat (2) @(posedge clk);
    chk(chip_state, 7'h40);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk(chip_state, 7'h01);
    chk(irq_out_n, 1'b0);
    w(OFS_CFG, 8'h00);
    wkt_host_model_i.service(d);
    chk(d, 32'h11);
    w(OFS_WIN, 8'h01);
    w(OFS_CFG, 8'h05);
    w(OFS_CMD, 8'h02);
    wait_sig(2, 2000, 1'b1);
    wait_sig(3, 1000, 1'b1);
    chk(n > 310 && n < 330, 1'b1);
    rx_sync_det <= 1'b1;
    wait_sig(2, 2000, 1'b1);
    wait_sig(3, 1000, 1'b1);
    chk(n > 630 && n < 650, 1'b1);
    rx_sync_det <= 1'b0;
    // A received packet ends the window early
    wait_sig(2, 2000, 1'b1);
    rx_pkt_done <= 1'b1;
    @(posedge clk);
    rx_pkt_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk(chip_state, 7'h01);
    w(OFS_CFG, 8'h00);
    wkt_host_model_i.service(d);
    chk(d, 32'h09);
    // Shutdown exit and periodic recalibration, with the RC sped up
    fast <= 1'b1;
    w(OFS_CMD, 8'h04);
    r(OFS_STATE);
    chk(d, 32'h04);
    w(OFS_CMD, 8'h08);
    wait_sig(4, 100, 1'b1);
    chk(chip_state, 7'h08);
    wait_sig(5, 3000, 1'b1);
    chk(rc_trim, 7'h40);
    w(OFS_CFG, 8'h10);
    wait_sig(4, 20000, 1'b1);
    chk(chip_state, 7'h08);
    wait_sig(5, 3000, 1'b1);
    chk(rc_trim, 7'h3F);
    w(OFS_CFG, 8'h00);
    r(OFS_STATUS);
    chk(d, 32'h02);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

/* wkt_cnt_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface wkt_cnt_if;
  logic        tick;
  logic        run;
  logic [15:0] mant;
  logic [4:0]  expo;
  logic        expire;
  modport owner(output tick, run, mant, expo, input expire);
  modport counter(input tick, run, mant, expo, output expire);
endinterface : wkt_cnt_if
`default_nettype wire

/* wkt_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host side: APB master, event service
// ----------------------------------------
module wkt_host_model
  import wkt_pkg::*;
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count assumed; a stuck slave ends the run
    do begin
      @(posedge clk);
      n++;
      if (n > 64) tb_top.hang();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Clear exactly what was seen, so a late event is not lost
  task automatic service(output logic [31:0] st);
    logic [31:0] x;
    logic        e;
    xfer(1'b0, OFS_STATUS, 32'h0, st, e);
    xfer(1'b1, OFS_STATUS, st, x, e);
  endtask : service
endmodule : wkt_host_model
`default_nettype wire

/* wkt_period_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module wkt_period_counter
  import wkt_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  wkt_cnt_if.counter cnt
);
  typedef struct packed {
    logic [33:0] pre;
    logic [15:0] steps;
    logic        expire;
  } wkt_cnt_s;

  wkt_cnt_s    st;
  wkt_cnt_s    next_st;
  logic [33:0] limit;

  // Wide prescaler so the largest exponent still fits
  assign limit = 34'(PRE_BASE) << cnt.expo;

  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (!cnt.run) begin
      next_st.pre = '0;
      next_st.steps = '0;
    end else if (cnt.tick) begin
      if (st.pre == limit - 34'h1) begin
        next_st.pre = '0;
        if (cnt.mant != 16'h0000 && st.steps == cnt.mant - 16'h0001) begin
          next_st.steps = '0;
          next_st.expire = 1'b1;
        end else begin
          next_st.steps = st.steps + 16'h0001;
        end
      end else begin
        next_st.pre = st.pre + 34'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cnt.expire = st.expire;

  a_expire_needs_tick: assert property (@(posedge clk) disable iff (rst)
    cnt.expire |-> $past(cnt.run) && $past(cnt.tick))
    else $error("expiry without a running tick");
endmodule : wkt_period_counter
`default_nettype wire

/* wkt_pkg.sv */
package wkt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_MANT_HI = 8'h04;
  localparam logic [7:0] OFS_MANT_LO = 8'h08;
  localparam logic [7:0] OFS_EXP     = 8'h0C;
  localparam logic [7:0] OFS_WIN     = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_CTRL    = 8'h1C;
  localparam logic [7:0] OFS_CMD     = 8'h20;
  localparam logic [7:0] OFS_STATE   = 8'h24;
  localparam logic [7:0] OFS_TRIM    = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_EN_BIT     = 0;
  localparam int CFG_BATT_BIT   = 1;
  localparam int CFG_DUTY_LSB   = 2;
  localparam int CFG_CAL_EN_BIT = 4;
  localparam int CFG_CAL_LSB    = 5;
  localparam int EXP_SLEEP_BIT  = 5;
  localparam int CTRL_XTAL_BIT  = 0;
  localparam int EV_WAKE = 0;
  localparam int EV_CAL  = 1;
  localparam int EV_BATT = 2;
  localparam int EV_RX   = 3;
  localparam int EV_TX   = 4;
  localparam int EV_W    = 5;
  localparam int CMD_BOOT     = 0;
  localparam int CMD_SLEEP    = 1;
  localparam int CMD_SHUTDOWN = 2;
  localparam int CMD_EXIT_SD  = 3;
  localparam int CMD_READY    = 4;
  localparam logic [1:0] DUTY_OFF = 2'h0;
  localparam logic [1:0] DUTY_RX  = 2'h1;
  localparam logic [1:0] DUTY_TX  = 2'h2;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [15:0] RST_MANT = 16'h0001;
  localparam logic [7:0]  RST_WIN  = 8'h01;
  localparam logic [6:0]  RST_TRIM = 7'h40;
  localparam int RC_HZ      = 32768;
  localparam int XO_HZ      = 30_000_000;
  localparam int XO_REF_DIV = 256;
  localparam int CAL_TICKS  = 32;
  localparam logic [15:0] CAL_EXPECT = 16'(XO_HZ / XO_REF_DIV * CAL_TICKS / RC_HZ);
  localparam int PRE_BASE   = 4;
  localparam int RECAL_LOG2 = 12;
  typedef enum logic [6:0] {
    ST_READY    = 7'h01,
    ST_SLEEP    = 7'h02,
    ST_SHUTDOWN = 7'h04,
    ST_CAL_WAIT = 7'h08,
    ST_CAL_MEAS = 7'h10,
    ST_RX       = 7'h20,
    ST_TX       = 7'h40
  } wkt_state_e;
endpackage : wkt_pkg

/* wkt_wake_timer.sv */
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module wkt_wake_timer
  import wkt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RC_CLK_32K,
  input  wire logic        XTAL_CLK_32K,
  input  wire logic        XO_REF,
  input  wire logic        XO_READY,
  input  wire logic        BATT_LOW,
  input  wire logic        RX_SYNC_DET,
  input  wire logic        RX_PKT_DONE,
  input  wire logic        TX_DONE,
  output logic             IRQ_OUT_N,
  output logic             XO_EN,
  output logic      [6:0]  RC_TRIM,
  output logic             RX_ON,
  output logic             TX_START,
  output logic             BATT_CHECK,
  output logic      [6:0]  CHIP_STATE
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]      cfg;
    logic [15:0]     mant;
    logic [4:0]      expo;
    logic            post_sleep;
    logic [7:0]      win;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic            src_xtal;
    logic [6:0]      trim;
    wkt_state_e      state;
    wkt_state_e      ret;
    logic            armed;
    logic            rx_seen;
    logic            rx_ext;
    logic [5:0]      cal_ticks;
    logic [15:0]     cal_cnt;
    logic [19:0]     recal;
    logic [2:0]      rc_s;
    logic [2:0]      xt_s;
    logic [2:0]      xr_s;
    logic [1:0]      rdy_s;
    logic [1:0]      batt_s;
    logic            xo_en;
    logic            tx_start;
    logic            batt_chk;
    logic [31:0]     rdata;
  } wkt_top_s;

  wkt_top_s        st;
  wkt_top_s        next_st;
  wkt_cnt_if       wake_if ();
  wkt_cnt_if       win_if ();
  logic [7:0]      wd;
  logic            wr;
  logic            wr_cmd;
  logic            rc_tick;
  logic            xt_tick;
  logic            xr_edge;
  logic            idle;
  logic            wake_exp;
  logic            win_exp;
  logic            recal_hit;
  logic [19:0]     recal_lim;
  logic [31:0]     rd_val;
  logic            addr_ok;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  wkt_state_e      post;

  assign wd = PWDATA[7:0];
  assign wr = PSEL & PENABLE & PWRITE;
  assign wr_cmd = wr && PADDR == OFS_CMD;
  // Edges come from the second and third stages only
  assign rc_tick = st.rc_s[1] & ~st.rc_s[2];
  assign xt_tick = st.xt_s[1] & ~st.xt_s[2];
  assign xr_edge = st.xr_s[1] & ~st.xr_s[2];
  assign idle = st.state == ST_READY || st.state == ST_SLEEP;
  assign post = st.post_sleep ? ST_SLEEP : ST_READY;
  assign recal_lim = 20'h00001 << (5'(st.cfg[CFG_CAL_LSB +: 3]) + 5'(RECAL_LOG2));
  assign recal_hit = st.cfg[CFG_CAL_EN_BIT] && idle && rc_tick
                     && st.recal == recal_lim - 20'h00001;

  // ----------------------------------------
  // Period counters
  // ----------------------------------------
  assign wake_if.tick = st.src_xtal ? xt_tick : rc_tick;
  assign wake_if.run = st.armed & st.cfg[CFG_EN_BIT];
  assign wake_if.mant = st.mant;
  assign wake_if.expo = st.expo;
  assign wake_exp = wake_if.expire;
  assign win_if.tick = wake_if.tick;
  assign win_if.run = st.state == ST_RX;
  assign win_if.mant = {8'h00, st.win};
  assign win_if.expo = st.expo;
  assign win_exp = win_if.expire;

  wkt_period_counter u_wake (
    .clk (CLK),
    .rst (RST),
    .cnt (wake_if)
  );

  wkt_period_counter u_win (
    .clk (CLK),
    .rst (RST),
    .cnt (win_if)
  );

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  always_comb begin
    rd_val = '0;
    addr_ok = 1'b1;
    if (PADDR == OFS_CFG) begin
      rd_val[7:0] = st.cfg;
    end else if (PADDR == OFS_MANT_HI) begin
      rd_val[7:0] = st.mant[15:8];
    end else if (PADDR == OFS_MANT_LO) begin
      rd_val[7:0] = st.mant[7:0];
    end else if (PADDR == OFS_EXP) begin
      rd_val[4:0] = st.expo;
      rd_val[EXP_SLEEP_BIT] = st.post_sleep;
    end else if (PADDR == OFS_WIN) begin
      rd_val[7:0] = st.win;
    end else if (PADDR == OFS_STATUS) begin
      rd_val[EV_W-1:0] = st.status;
    end else if (PADDR == OFS_MASK) begin
      rd_val[EV_W-1:0] = st.mask;
    end else if (PADDR == OFS_CTRL) begin
      rd_val[CTRL_XTAL_BIT] = st.src_xtal;
    end else if (PADDR == OFS_CMD) begin
      rd_val = '0;
    end else if (PADDR == OFS_STATE) begin
      rd_val[6:0] = st.state;
    end else if (PADDR == OFS_TRIM) begin
      rd_val[6:0] = st.trim;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.tx_start = 1'b0;
    next_st.batt_chk = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    next_st.rc_s = {st.rc_s[1:0], RC_CLK_32K};
    next_st.xt_s = {st.xt_s[1:0], XTAL_CLK_32K};
    next_st.xr_s = {st.xr_s[1:0], XO_REF};
    next_st.rdy_s = {st.rdy_s[0], XO_READY};
    next_st.batt_s = {st.batt_s[0], BATT_LOW};
    if (PSEL && !PENABLE) begin
      next_st.rdata = rd_val;
    end
    if (wr) begin
      if (PADDR == OFS_CFG) begin
        next_st.cfg = wd;
      end else if (PADDR == OFS_MANT_HI) begin
        next_st.mant[15:8] = wd;
      end else if (PADDR == OFS_MANT_LO) begin
        next_st.mant[7:0] = wd;
      end else if (PADDR == OFS_EXP) begin
        next_st.expo = wd[4:0];
        next_st.post_sleep = wd[EXP_SLEEP_BIT];
      end else if (PADDR == OFS_WIN) begin
        next_st.win = wd;
      end else if (PADDR == OFS_STATUS) begin
        ev_clr = wd[EV_W-1:0];
      end else if (PADDR == OFS_MASK) begin
        next_st.mask = wd[EV_W-1:0];
      end else if (PADDR == OFS_CTRL) begin
        next_st.src_xtal = wd[CTRL_XTAL_BIT];
      end
    end
    if (!st.cfg[CFG_EN_BIT]) begin
      next_st.armed = 1'b0;
    end
    case (st.state)
      ST_CAL_WAIT: begin
        if (st.rdy_s[1]) begin
          next_st.state = ST_CAL_MEAS;
          next_st.cal_ticks = '0;
          next_st.cal_cnt = '0;
        end
      end
      ST_CAL_MEAS: begin
        // Raw RC edges: the trim acts on the RC, whatever source is chosen
        if (xr_edge) begin
          next_st.cal_cnt = st.cal_cnt + 16'h0001;
        end
        if (rc_tick) begin
          next_st.cal_ticks = st.cal_ticks + 6'h01;
        end
        if (st.cal_ticks == 6'(CAL_TICKS)) begin
          if (st.cal_cnt > CAL_EXPECT && st.trim != 7'h7F) begin
            next_st.trim = st.trim + 7'h01;
          end else if (st.cal_cnt < CAL_EXPECT && st.trim != 7'h00) begin
            next_st.trim = st.trim - 7'h01;
          end
          next_st.xo_en = 1'b0;
          next_st.state = st.ret;
          ev_set[EV_CAL] = 1'b1;
        end
      end
      ST_RX: begin
        if (RX_SYNC_DET) begin
          next_st.rx_seen = 1'b1;
        end
        if (RX_PKT_DONE) begin
          ev_set[EV_RX] = 1'b1;
          next_st.state = post;
        end else if (win_exp) begin
          if (st.rx_seen && !st.rx_ext) begin
            next_st.rx_ext = 1'b1;
          end else begin
            next_st.state = post;
          end
        end
      end
      ST_TX: begin
        if (TX_DONE) begin
          ev_set[EV_TX] = 1'b1;
          next_st.state = post;
        end
      end
      default: begin
      end
    endcase
    if (wake_exp) begin
      ev_set[EV_WAKE] = 1'b1;
      if (st.cfg[CFG_BATT_BIT]) begin
        next_st.batt_chk = 1'b1;
        ev_set[EV_BATT] = st.batt_s[1];
      end
      if (idle) begin
        case (st.cfg[CFG_DUTY_LSB +: 2])
          DUTY_RX: begin
            next_st.state = ST_RX;
            next_st.rx_seen = 1'b0;
            next_st.rx_ext = 1'b0;
          end
          DUTY_TX: begin
            next_st.state = ST_TX;
            next_st.tx_start = 1'b1;
          end
          default: begin
            next_st.state = post;
          end
        endcase
      end
    end else if (recal_hit) begin
      next_st.state = ST_CAL_WAIT;
      next_st.ret = st.state;
      next_st.xo_en = 1'b1;
    end
    if (!(st.cfg[CFG_CAL_EN_BIT] && idle) || recal_hit) begin
      next_st.recal = '0;
    end else if (rc_tick) begin
      next_st.recal = st.recal + 20'h00001;
    end
    // Commands win over timer events issued in the same cycle
    if (wr_cmd) begin
      if (wd[CMD_BOOT]) begin
        next_st.state = ST_CAL_WAIT;
        next_st.ret = ST_READY;
        next_st.xo_en = 1'b1;
      end else if (wd[CMD_EXIT_SD] && st.state == ST_SHUTDOWN) begin
        next_st.state = ST_CAL_WAIT;
        next_st.ret = ST_READY;
        next_st.xo_en = 1'b1;
      end else if (wd[CMD_SHUTDOWN]) begin
        next_st.state = ST_SHUTDOWN;
        next_st.armed = 1'b0;
        next_st.xo_en = 1'b0;
      end else if (wd[CMD_SLEEP] && st.state == ST_READY) begin
        next_st.state = ST_SLEEP;
        next_st.armed = st.cfg[CFG_EN_BIT];
      end else if (wd[CMD_READY] && st.state == ST_SLEEP) begin
        next_st.state = ST_READY;
      end
    end
    // A new event beats a clear in the same cycle
    next_st.status = (st.status & ~ev_clr) | ev_set;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
      st.state <= ST_READY;
      st.ret <= ST_READY;
      st.mant <= RST_MANT;
      st.win <= RST_WIN;
      st.trim <= RST_TRIM;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA = st.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign IRQ_OUT_N = ~|(st.status & st.mask);
  assign XO_EN = st.xo_en;
  assign RC_TRIM = st.trim;
  assign RX_ON = st.state == ST_RX;
  assign TX_START = st.tx_start;
  assign BATT_CHECK = st.batt_chk;
  assign CHIP_STATE = st.state;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_wake_idle;
    wake_exp && idle && !wr_cmd;
  endsequence

  sequence s_boot_write;
    wr_cmd && wd[CMD_BOOT];
  endsequence

  a_wake_sets_flag: assert property (wake_exp |=> st.status[EV_WAKE])
    else $error("wake expiry did not set its flag");
  a_irq_on_wake: assert property (
    wake_exp && st.mask[EV_WAKE] && !(wr && PADDR == OFS_MASK) |=> !IRQ_OUT_N)
    else $error("unmasked wake did not pull interrupt low");
  a_duty_rx_start: assert property (
    s_wake_idle ##0 st.cfg[CFG_DUTY_LSB +: 2] == DUTY_RX |=> RX_ON ##1 RX_ON)
    else $error("receive duty mode did not start receive");
  a_duty_tx_start: assert property (
    s_wake_idle ##0 st.cfg[CFG_DUTY_LSB +: 2] == DUTY_TX |=> TX_START ##1 !TX_START)
    else $error("transmit duty mode did not pulse start");
  a_post_wake_state: assert property (
    s_wake_idle ##0 st.cfg[CFG_DUTY_LSB +: 2] == DUTY_OFF
    |=> st.state == ($past(st.post_sleep) ? ST_SLEEP : ST_READY))
    else $error("wrong state after wake");
  a_disabled_no_wake: assert property (!st.cfg[CFG_EN_BIT] |=> !wake_exp)
    else $error("expiry while timer disabled");
  a_batt_on_wake: assert property (
    wake_exp && st.cfg[CFG_BATT_BIT] |=> BATT_CHECK ##1 !BATT_CHECK)
    else $error("battery check missing at expiry");
  a_cal_xo_running: assert property (st.state == ST_CAL_MEAS |-> XO_EN)
    else $error("measuring without crystal enabled");
  a_boot_starts_cal: assert property (
    s_boot_write |=> st.state == ST_CAL_WAIT && XO_EN)
    else $error("boot did not start calibration");
  a_recal_starts: assert property (
    recal_hit && !wake_exp && !wr_cmd |=> st.state == ST_CAL_WAIT)
    else $error("periodic recalibration did not start");
  a_rx_gives_up: assert property (
    st.state == ST_RX && win_exp && !st.rx_seen && !RX_PKT_DONE && !wr_cmd
    |=> st.state != ST_RX)
    else $error("receive window not closed");
  a_tx_returns: assert property (
    st.state == ST_TX && TX_DONE && !wr_cmd |=> st.state != ST_TX && st.status[EV_TX])
    else $error("transmit did not return");
endmodule : wkt_wake_timer
`default_nettype wire
